//--- verilog/prm_power_reset_manager.v
// Power and reset manager: brownout, power-on, idle, power-down, reset pin.
// Assumes detector and wakeup inputs are synchronous to pclk; APB slave.
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "prm_consts.vh"

module prm_power_reset_manager #(
    parameter XTAL_COUNT = `PRM_START_XTAL,
    parameter RC_COUNT = `PRM_START_RC
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire power_on_detect,
    input wire brownout_detect,
    input wire reset_pin_in,
    input wire watchdog_overflow,
    input wire wdt_irq_enable,
    input wire ext0_wake,
    input wire ext1_wake,
    input wire kbd_wake,
    input wire cmp1_wake,
    input wire cmp2_wake,
    input wire adc_wake,
    input wire adc_enabled,
    input wire [7:0] wake_irq_enable,
    input wire global_irq_enable,
    input wire brownout_irq_enable,
    input wire wake_priority_ok,
    output reg cpu_reset,
    output wire cpu_halt,
    output wire osc_run,
    output wire brownout_level_select,
    output wire brownout_irq,
    output wire eprom_analog_off,
    output wire reset_pin_gpio,
    output wire analog_keep_alive
);
    ////////////////////////////////////////////////////////////////////
    localparam [3:0] ST_RUN = 4'b0001;
    localparam [3:0] ST_IDLE = 4'b0010;
    localparam [3:0] ST_PDOWN = 4'b0100;
    localparam [3:0] ST_START = 4'b1000;

    reg [3:0] state_reg, state_next;
    reg idle_request_reg, powerdown_request_reg;
    reg brownout_flag_reg, power_on_flag_reg;
    reg brownout_disable_reg, brownout_irq_select_reg;
    reg low_voltage_eprom_reg;
    reg [7:0] user_config_byte_reg;
    reg bo_prev_reg;
    reg bo_irq_reg;
    reg por_seen_reg;
    wire wr_en, rd_en, addr_ok;
    wire bo_active, bo_reset, bo_irq_event;
    wire wake_irq, wake_reset, start_busy, start_done;
    wire pin_reset, any_reset, xtal_mode;

    ////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    assign pready = 1'b1;
    assign addr_ok = (paddr == `PRM_OFF_PWR_CTRL) ||
        (paddr == `PRM_OFF_AUX_ONE) || (paddr == `PRM_OFF_AUX) ||
        (paddr == `PRM_OFF_CONFIG) || (paddr == `PRM_OFF_STATUS);
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;

    ////////////////////////////////////////////////////////////////////
    // Brownout decision
    assign brownout_level_select =
        user_config_byte_reg[`PRM_CF_BOV];
    assign bo_active = brownout_detect && !brownout_disable_reg;
    assign bo_reset = bo_active &&
        !brownout_irq_select_reg;
    assign bo_irq_event = bo_active && !bo_prev_reg &&
        brownout_irq_select_reg;
    assign brownout_irq = bo_irq_reg;

    assign pin_reset = !user_config_byte_reg[`PRM_CF_RPD] &&
        !reset_pin_in;
    assign reset_pin_gpio = user_config_byte_reg[`PRM_CF_RPD];
    // Watchdog reset needs no main clock, so it acts in power-down
    assign wake_reset = bo_reset || pin_reset || power_on_detect ||
        (watchdog_overflow &&
        user_config_byte_reg[`PRM_CF_WATCHDOG_RESET_ENABLE]);
    assign any_reset = wake_reset;

    // Wakeup interrupt sources, each gated by its own enable
    assign wake_irq = global_irq_enable && wake_priority_ok && (
        (ext0_wake && wake_irq_enable[0]) ||
        (ext1_wake && wake_irq_enable[1]) ||
        (kbd_wake && wake_irq_enable[2]) ||
        (cmp1_wake && wake_irq_enable[3]) ||
        (cmp2_wake && wake_irq_enable[4]) ||
        (watchdog_overflow && !user_config_byte_reg[`PRM_CF_WATCHDOG_RESET_ENABLE] &&
            wdt_irq_enable) ||
        (bo_active && brownout_irq_select_reg &&
            brownout_irq_enable) ||
        (adc_wake && adc_enabled && wake_irq_enable[5] &&
            user_config_byte_reg[`PRM_CF_CONVERTER_RC_CLOCK_SELECT]));

    assign xtal_mode = user_config_byte_reg[`PRM_CF_XTAL];

    ////////////////////////////////////////////////////////////////////
    // Low-power state machine
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (powerdown_request_reg)
                    state_next = ST_PDOWN;
                else if (idle_request_reg)
                    state_next = ST_IDLE;
            end
            ST_IDLE: begin
                if (wake_irq)
                    state_next = ST_RUN;
            end
            ST_PDOWN: begin
                if (wake_irq)
                    state_next = ST_START;
            end
            ST_START: begin
                if (start_done)
                    state_next = ST_RUN;
            end
            default: state_next = ST_RUN;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_RUN;
            cpu_reset <= 1'b1;
        end else begin
            cpu_reset <= any_reset;
            if (any_reset)
                state_reg <= ST_RUN;
            else
                state_reg <= state_next;
        end
    end

    // Oscillator restarts as soon as power-down is left
    assign osc_run = (state_reg != ST_PDOWN);
    assign cpu_halt = (state_reg != ST_RUN) || start_busy;
    assign analog_keep_alive = 1'b1;
    assign eprom_analog_off = low_voltage_eprom_reg;

    prm_startup_timer #(
        .CNT_W(`PRM_CNT_W),
        .XTAL_COUNT(XTAL_COUNT),
        .RC_COUNT(RC_COUNT)
    ) u_startup (
        .pclk(pclk),
        .presetn(presetn),
        // A reset in the wake cycle skips the wait, so no count then
        .start(state_reg == ST_PDOWN && state_next == ST_START &&
            !any_reset),
        .xtal_mode(xtal_mode),
        .busy(start_busy),
        .done(start_done)
    );

    ////////////////////////////////////////////////////////////////////
    // Control and flag registers; set beats software clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_request_reg <= 1'b0;
            powerdown_request_reg <= 1'b0;
            brownout_flag_reg <= 1'b0;
            power_on_flag_reg <= 1'b0;
            brownout_disable_reg <= 1'b0;
            brownout_irq_select_reg <= 1'b0;
            low_voltage_eprom_reg <= 1'b0;
            user_config_byte_reg <= `PRM_RST_CONFIG;
            bo_prev_reg <= 1'b0;
            bo_irq_reg <= 1'b0;
            por_seen_reg <= 1'b0;
        end else begin
            bo_prev_reg <= bo_active;
            bo_irq_reg <= bo_irq_event && brownout_irq_enable;
            por_seen_reg <= power_on_detect;
            if (wr_en && paddr == `PRM_OFF_PWR_CTRL) begin
                idle_request_reg <= pwdata[`PRM_PC_IDLE];
                powerdown_request_reg <= pwdata[`PRM_PC_PDOWN];
                if (!pwdata[`PRM_PC_BOF])
                    brownout_flag_reg <= 1'b0;
                if (!pwdata[`PRM_PC_POF])
                    power_on_flag_reg <= 1'b0;
            end
            if (wr_en && paddr == `PRM_OFF_AUX_ONE) begin
                brownout_irq_select_reg <= pwdata[`PRM_A1_BOI];
                brownout_disable_reg <= pwdata[`PRM_A1_BOD];
            end
            // Set-only from software: only power-on clears it
            if (wr_en && paddr == `PRM_OFF_AUX && pwdata[`PRM_AX_LOW_VOLTAGE_EPROM])
                low_voltage_eprom_reg <= 1'b1;
            if (wr_en && paddr == `PRM_OFF_CONFIG)
                user_config_byte_reg <= pwdata[7:0];
            if (bo_active)
                brownout_flag_reg <= 1'b1;
            if (power_on_detect && !por_seen_reg)
                power_on_flag_reg <= 1'b1;
            if (power_on_detect)
                low_voltage_eprom_reg <= 1'b0;
            // Exit of either low-power state drops both requests
            if (any_reset || (state_reg == ST_IDLE && wake_irq) ||
                    (state_reg == ST_PDOWN && wake_irq)) begin
                idle_request_reg <= 1'b0;
                powerdown_request_reg <= 1'b0;
            end
            // Reset returns the brownout disable and interrupt select to defaults
            if (any_reset) begin
                brownout_disable_reg <= 1'b0;
                brownout_irq_select_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data registered in the setup phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= 32'h0000_0000;
            case (paddr)
                `PRM_OFF_PWR_CTRL: begin
                    prdata[`PRM_PC_IDLE] <= idle_request_reg;
                    prdata[`PRM_PC_PDOWN] <= powerdown_request_reg;
                    prdata[`PRM_PC_POF] <= power_on_flag_reg;
                    prdata[`PRM_PC_BOF] <= brownout_flag_reg;
                end
                `PRM_OFF_AUX_ONE: begin
                    prdata[`PRM_A1_BOI] <= brownout_irq_select_reg;
                    prdata[`PRM_A1_BOD] <= brownout_disable_reg;
                end
                `PRM_OFF_AUX: prdata[`PRM_AX_LOW_VOLTAGE_EPROM] <= low_voltage_eprom_reg;
                `PRM_OFF_CONFIG: prdata[7:0] <= user_config_byte_reg;
                `PRM_OFF_STATUS: begin
                    prdata[3:0] <= state_reg;
                    prdata[4] <= start_busy;
                    prdata[5] <= brownout_detect;
                end
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

//--- verilog/prm_consts.vh
// Constants for the power and reset manager: offsets, fields, counts.
// Included by the design files; holds definitions only.
`ifndef PRM_CONSTS_VH
`define PRM_CONSTS_VH

// Register byte offsets
`define PRM_OFF_PWR_CTRL 12'h000
`define PRM_OFF_AUX_ONE 12'h004
`define PRM_OFF_AUX 12'h008
`define PRM_OFF_CONFIG 12'h00C
`define PRM_OFF_STATUS 12'h010

// power_control fields
`define PRM_PC_IDLE 0
`define PRM_PC_PDOWN 1
`define PRM_PC_BOF 5
`define PRM_PC_POF 4
// aux_control_one fields
`define PRM_A1_BOI 5
`define PRM_A1_BOD 6
// aux_control fields
`define PRM_AX_LOW_VOLTAGE_EPROM 4
// user_config_byte fields
`define PRM_CF_BOV 0
`define PRM_CF_WATCHDOG_RESET_ENABLE 1
`define PRM_CF_RPD 2
`define PRM_CF_XTAL 3
`define PRM_CF_CONVERTER_RC_CLOCK_SELECT 4

// Reset values
`define PRM_RST_CONFIG 8'hFF
`define PRM_RST_ZERO 8'h00

// Oscillator start-up counts in CPU clocks
`define PRM_START_XTAL 1024
`define PRM_START_RC 256
`define PRM_CNT_W 11

`endif

//--- verilog/prm_startup_timer.v
// Oscillator start-up counter: counts CPU clocks after a restart.
// Assumes pclk keeps running in this model while the oscillator restarts.
`timescale 1ns/1ps
`include "prm_consts.vh"

module prm_startup_timer #(
    parameter CNT_W = `PRM_CNT_W,
    parameter XTAL_COUNT = `PRM_START_XTAL,
    parameter RC_COUNT = `PRM_START_RC
) (
    input wire pclk,
    input wire presetn,
    input wire start,
    input wire xtal_mode,
    output wire busy,
    output reg done
);
    localparam integer XTAL_M1 = XTAL_COUNT - 1;
    localparam integer RC_M1 = RC_COUNT - 1;
    localparam [CNT_W-1:0] XTAL_LAST = XTAL_M1[CNT_W-1:0];
    localparam [CNT_W-1:0] RC_LAST = RC_M1[CNT_W-1:0];

    reg [CNT_W-1:0] count_reg;
    reg run_reg;

    assign busy = run_reg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= {CNT_W{1'b0}};
            run_reg <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                count_reg <= {CNT_W{1'b0}};
                run_reg <= 1'b1;
            end else if (run_reg) begin
                // Length follows oscillator type
                if (count_reg == (xtal_mode ? XTAL_LAST : RC_LAST)) begin
                    run_reg <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

//--- test/prm_monitor.sv
// Checker for the power and reset manager, bound to its top module.
// Sees the top module's ports only; one clock, reset presetn.
`timescale 1ns/1ps
module prm_monitor #(
    parameter XTAL_COUNT = 1024,
    parameter RC_COUNT = 256
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire power_on_detect,
    input wire brownout_detect,
    input wire reset_pin_in,
    input wire watchdog_overflow,
    input wire brownout_irq_enable,
    input wire cpu_reset,
    input wire cpu_halt,
    input wire osc_run,
    input wire brownout_level_select,
    input wire brownout_irq,
    input wire eprom_analog_off,
    input wire reset_pin_gpio,
    input wire analog_keep_alive
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
////////////////////////////////////////
sequence s_wr(logic [11:0] a);
    psel && penable && pwrite && paddr == a;
endsequence
sequence s_bo_fire;
    brownout_irq ##1 brownout_detect;
endsequence
// Reset-driven wakes skip the start-up wait, so exclude them
sequence s_wake;
    (!osc_run && !watchdog_overflow && !cpu_reset) ##1
    (osc_run && !cpu_reset);
endsequence
////////////////////////////////////////
chk_por_reset: assert property (
    power_on_detect |=> cpu_reset) else $error("no power-on reset");
chk_pin_reset: assert property (
    !reset_pin_gpio && !reset_pin_in |=> cpu_reset)
    else $error("reset pin ignored");
chk_level_sel: assert property (
    s_wr(12'h00c) |=> brownout_level_select == $past(pwdata[0]))
    else $error("level select wrong");
chk_bo_cause: assert property (
    brownout_irq |-> $past(brownout_detect) && $past(brownout_irq_enable))
    else $error("brownout irq without cause");
chk_bo_once: assert property (
    s_bo_fire |-> !brownout_irq) else $error("brownout irq repeated");
chk_pdown_osc: assert property (
    s_wr(12'h000) ##0 (pwdata[1] && !cpu_halt && !cpu_reset && reset_pin_in
    && !power_on_detect && !watchdog_overflow && !brownout_detect)
    |=> ##1 !osc_run) else $error("oscillator not stopped");
chk_halt_pdown: assert property (
    !osc_run |-> cpu_halt) else $error("cpu runs without oscillator");
chk_start_wait: assert property (
    s_wake |-> cpu_halt [*6]) else $error("start-up wait too short");
chk_eprom_set: assert property (
    s_wr(12'h008) ##0 pwdata[4] |=> eprom_analog_off)
    else $error("eprom analog not off");
chk_keep_alive: assert property (
    analog_keep_alive) else $error("analog blocks dropped");
endmodule
bind prm_power_reset_manager prm_monitor #(.XTAL_COUNT(XTAL_COUNT),
    .RC_COUNT(RC_COUNT)) i_prm_monitor (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .power_on_detect(power_on_detect),
    .brownout_detect(brownout_detect), .reset_pin_in(reset_pin_in),
    .watchdog_overflow(watchdog_overflow),
    .brownout_irq_enable(brownout_irq_enable), .cpu_reset(cpu_reset),
    .cpu_halt(cpu_halt), .osc_run(osc_run),
    .brownout_level_select(brownout_level_select),
    .brownout_irq(brownout_irq), .eprom_analog_off(eprom_analog_off),
    .reset_pin_gpio(reset_pin_gpio), .analog_keep_alive(analog_keep_alive));

//--- test/test_prm_power_reset_manager.sv
// Self-checking bench for the power and reset manager.
// Drives APB, detectors and wake inputs itself; short start-up counts.
`timescale 1ns/1ps
module test_prm_power_reset_manager;
localparam XC = 16;
localparam RC = 8;
logic pclk, err, rs;
logic presetn = 0, psel = 0, penable = 0, pwrite = 0, por = 1, bo = 0;
logic pin = 1, wdo = 0, wie = 0, gie = 1, bie = 1, pri = 0, adce = 0;
logic [11:0] paddr = 0;
logic [31:0] pwdata = 0, q;
logic [5:0] wk = 0;
logic [7:0] en = 0, n;
wire [31:0] prdata;
wire pready, pslverr, cpu_reset, cpu_halt, osc_run, lvl, boirq, epr, gpio;
wire ka;
int error_cnt = 0;
int compares = 0;
prm_power_reset_manager #(.XTAL_COUNT(XC), .RC_COUNT(RC))
    i_prm_power_reset_manager (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_on_detect(por), .brownout_detect(bo), .reset_pin_in(pin),
    .watchdog_overflow(wdo), .wdt_irq_enable(wie), .ext0_wake(wk[0]),
    .ext1_wake(wk[1]), .kbd_wake(wk[2]), .cmp1_wake(wk[3]),
    .cmp2_wake(wk[4]), .adc_wake(wk[5]), .adc_enabled(adce),
    .wake_irq_enable(en), .global_irq_enable(gie),
    .brownout_irq_enable(bie), .wake_priority_ok(pri),
    .cpu_reset(cpu_reset), .cpu_halt(cpu_halt), .osc_run(osc_run),
    .brownout_level_select(lvl), .brownout_irq(boirq),
    .eprom_analog_off(epr), .reset_pin_gpio(gpio), .analog_keep_alive(ka));
////////////////////////////////////////
initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
end
task test_done;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask
task chk(input [31:0] g, input [31:0] e);
    compares++;
    if (g !== e) begin
        error_cnt++;
        $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
endtask
task cyc(input int k);
    repeat (k) @(posedge pclk);
    @(negedge pclk);
endtask
// Zero-wait slave, but the loop still waits on pready
task xf(input w, input [11:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task bo_run;
    @(posedge pclk);
    bo <= 1'b1;
    n = 0;
    rs = 0;
    repeat (6) begin
        @(negedge pclk);
        n = n + boirq;
        rs = rs | cpu_reset;
    end
    @(posedge pclk);
    bo <= 1'b0;
endtask
////////////////////////////////////////
task t_por;
    cyc(2);
    chk(cpu_reset, 1);
    @(posedge pclk);
    por <= 1'b0;
    cyc(3);
    chk(cpu_reset, 0);
    xf(0, 12'h000, 0);
    chk(q[4], 1);
    xf(1, 12'h000, 0);
    xf(0, 12'h000, 0);
    chk(q[4], 0);
    xf(0, 12'h00c, 0);
    chk(q[7:0], 8'hff);
    xf(1, 12'h00c, 8'hfe);
    cyc(0);
    chk(lvl, 0);
    xf(1, 12'h00c, 8'hff);
    xf(0, 12'h020, 0);
    chk(err, 1);
    chk(q, 0);
endtask
task t_bo;
    @(posedge pclk);
    bo <= 1'b1;
    cyc(2);
    chk(cpu_reset, 1);
    @(posedge pclk);
    bo <= 1'b0;
    cyc(3);
    xf(0, 12'h000, 0);
    chk(q[5], 1);
    xf(1, 12'h004, 32'h0000_0020);
    bo_run;
    chk({rs, n}, 1);
    // Every wake interrupt source is gated by the priority input
    @(posedge pclk);
    pri <= 1'b1;
    xf(1, 12'h000, 2);
    bo_run;
    cyc(0);
    chk(osc_run, 1);
    cyc(20);
    xf(1, 12'h004, 32'h0000_0060);
    bo_run;
    chk({rs, n}, 0);
    xf(1, 12'h004, 0);
endtask
task t_pd(input [31:0] cfg, input int c);
    int m;
    xf(1, 12'h00c, cfg);
    xf(1, 12'h000, 2);
    @(posedge pclk);
    en <= 0;
    pri <= 1'b1;
    wk <= 6'h01;
    cyc(3);
    chk(osc_run, 0);
    chk(ka, 1);
    @(posedge pclk);
    en <= 8'h01;
    pri <= 1'b0;
    cyc(3);
    chk(osc_run, 0);
    @(posedge pclk);
    pri <= 1'b1;
    m = 0;
    while (osc_run !== 1'b1 && m < 9) begin
        @(negedge pclk);
        m++;
    end
    m = 0;
    while (cpu_halt === 1'b1 && m < 99) begin
        @(negedge pclk);
        m++;
    end
    chk(m >= c && m <= c + 2, 1);
    @(posedge pclk);
    wk <= 0;
    xf(0, 12'h000, 0);
    chk(q[1:0], 0);
endtask
task t_idle;
    xf(1, 12'h000, 1);
    cyc(1);
    chk({cpu_halt, osc_run}, 3);
    @(posedge pclk);
    en <= 8'h04;
    wk <= 6'h04;
    cyc(3);
    chk(cpu_halt, 0);
    @(posedge pclk);
    wk <= 0;
    xf(0, 12'h000, 0);
    chk(q[0], 0);
endtask
task t_adc;
    xf(1, 12'h00c, 8'hef);
    xf(1, 12'h000, 2);
    @(posedge pclk);
    adce <= 1'b1;
    en <= 8'h20;
    wk <= 6'h20;
    cyc(3);
    chk(osc_run, 0);
    xf(1, 12'h00c, 8'hff);
    cyc(2);
    chk(osc_run, 1);
    @(posedge pclk);
    wk <= 0;
    cyc(20);
endtask
task t_wdt;
    xf(1, 12'h000, 2);
    @(posedge pclk);
    wdo <= 1'b1;
    cyc(2);
    chk(cpu_reset, 1);
    @(posedge pclk);
    wdo <= 1'b0;
    cyc(20);
    xf(1, 12'h00c, 8'hfd);
    xf(1, 12'h000, 2);
    @(posedge pclk);
    wie <= 1'b1;
    wdo <= 1'b1;
    cyc(3);
    chk({cpu_reset, osc_run}, 1);
    @(posedge pclk);
    wdo <= 1'b0;
    cyc(20);
endtask
task t_pin;
    xf(1, 12'h00c, 8'hff);
    @(posedge pclk);
    pin <= 1'b0;
    cyc(3);
    chk({cpu_reset, gpio}, 1);
    @(posedge pclk);
    pin <= 1'b1;
    xf(1, 12'h00c, 8'hfb);
    @(posedge pclk);
    pin <= 1'b0;
    cyc(5);
    chk({cpu_reset, gpio}, 2);
    @(posedge pclk);
    pin <= 1'b1;
    cyc(3);
    chk(cpu_reset, 0);
endtask
task t_ep;
    xf(1, 12'h008, 32'h0000_0010);
    xf(1, 12'h008, 0);
    cyc(0);
    chk(epr, 1);
    @(posedge pclk);
    por <= 1'b1;
    cyc(3);
    @(posedge pclk);
    por <= 1'b0;
    cyc(3);
    chk(epr, 0);
endtask
////////////////////////////////////////
initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_por;
    t_bo;
    t_pd(8'hff, XC);
    t_pd(8'hf7, RC);
    t_idle;
    t_adc;
    t_wdt;
    t_pin;
    t_ep;
    test_done;
end
// Whole run is well under 2000 cycles
initial begin
    #200000;
    error_cnt++;
    test_done;
end
endmodule
